// [hdl/bmf_framer.v]
// Bus monitor PCM framer: captures classified 1553 words, adds time and
// labels, and emits fixed-length PCM frames. Words arrive pre-decoded
// from a 1553 receiver on this clock; time and user inputs are async.
`timescale 1ns/10ps
`default_nettype none
`include "bmf_map.vh"
module bmf_framer #(
  parameter DEPTH_LOG2 = 6,
  parameter RATE_DIV = 16'd250,
  parameter USER_DIV = 16'd1024,
  parameter NORESP_US = 14
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Configuration (static)
  input wire [8:0] frameLen,
  input wire busSecondary,
  // Decoded 1553 words
  input wire wordStrobe,
  input wire [1:0] wordKind,
  input wire [15:0] wordValue,
  input wire wordError,
  input wire busIdle,
  // External time and user word inputs
  input wire [47:0] timeIn,
  input wire [15:0] userIn,
  // PCM output
  output reg pcmData,
  output reg pcmWordStart,
  output reg pcmFrameStart,
  output reg overflowSeen
);
  localparam ST_IDLE = 2'h0;
  localparam ST_TAG = 2'h1;
  localparam ST_MSG = 2'h2;
  localparam [31:0] NORESP_CYC = NORESP_US * `BMF_CLK_MHZ;
  // Time and user input synchronisers
  reg [47:0] timeMeta;
  reg [47:0] timeSync;
  reg [47:0] timeLast;
  reg [47:0] timeCoh;
  reg [15:0] userMeta;
  reg [15:0] userSync;
  reg [15:0] userLast;
  reg [15:0] userCoh;
  // Bits of a wide async word may land in different cycles; a value is
  // taken only once two samples agree, so a torn word never gets out
  always @(posedge clk) begin
    timeMeta <= timeIn;
    timeSync <= timeMeta;
    timeLast <= timeSync;
    if (timeSync == timeLast)
      timeCoh <= timeSync; // [R09]
    userMeta <= userIn;
    userSync <= userMeta;
    userLast <= userSync;
    if (userSync == userLast)
      userCoh <= userSync;
  end
  // Message sequencer
  reg [1:0] state;
  reg [1:0] tagStep;
  reg [47:0] tagLatch;
  reg [15:0] respCnt;
  reg respRun;
  reg [15:0] gapCnt;
  reg msgDone;
  // Message FIFO
  reg [19:0] fifo [0:(1<<DEPTH_LOG2)-1];
  reg [DEPTH_LOG2:0] wrPtr;
  reg [DEPTH_LOG2:0] rdPtr;
  reg ovflPending;
  reg [19:0] pushWord;
  reg pushEn;
  // Fill kept at pointer width so the difference wraps with the pointers
  wire [DEPTH_LOG2:0] fifoFill = wrPtr - rdPtr;
  wire fifoFull = fifoFill[DEPTH_LOG2];
  wire fifoEmpty = (wrPtr == rdPtr);
  wire [3:0] errId = busSecondary ? `BMF_ID_ERR_SEC : `BMF_ID_ERR_PRI;
  always @* begin
    pushEn = 1'b0;
    pushWord = 20'h00000;
    if (ovflPending && !fifoFull) begin
      pushEn = 1'b1;
      pushWord = {`BMF_ID_OVFL, 16'h0000}; // [R16]
    end else if (state == ST_TAG) begin
      pushEn = 1'b1;
      case (tagStep) // [R08] [R09]
        2'h0: pushWord = {`BMF_ID_HIGH, tagLatch[47:32]};
        2'h1: pushWord = {`BMF_ID_LOW, tagLatch[31:16]};
        default: pushWord = {`BMF_ID_USEC, tagLatch[15:0]};
      endcase
    end else if (respRun && wordStrobe && wordKind == `BMF_KIND_STAT) begin
      pushEn = 1'b1;
      pushWord = {`BMF_ID_STAT, wordValue};
    end else if (wordStrobe) begin
      pushEn = 1'b1;
      if (wordError)
        pushWord = {errId, wordValue}; // [R15]
      else if (wordKind == `BMF_KIND_CMD)
        pushWord = {`BMF_ID_CMD, wordValue}; // [R11]
      else if (wordKind == `BMF_KIND_STAT)
        pushWord = {`BMF_ID_STAT, wordValue};
      else
        pushWord = {`BMF_ID_DATA, wordValue};
    end else if (state == ST_MSG && respRun == 1'b0 && respCnt != 16'h0000) begin
      pushEn = 1'b1;
      pushWord = {`BMF_ID_RESP, respCnt}; // [R02]
    end
  end
  // Note: a bus word landing during the tag burst is held off by the
  // 1553 word time (20 us), far longer than the three-cycle burst.
  always @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
      tagStep <= 2'h0;
      tagLatch <= 48'h0;
      respCnt <= 16'h0000;
      respRun <= 1'b0;
      gapCnt <= 16'h0000;
      msgDone <= 1'b0;
      wrPtr <= {(DEPTH_LOG2+1){1'b0}};
      ovflPending <= 1'b0;
    end else begin
      if (pushEn && !(ovflPending && !fifoFull)) begin
        if (fifoFull)
          ovflPending <= 1'b1;
        else begin
          fifo[wrPtr[DEPTH_LOG2-1:0]] <= pushWord;
          wrPtr <= wrPtr + 1'b1;
        end
      end else if (pushEn) begin
        fifo[wrPtr[DEPTH_LOG2-1:0]] <= pushWord;
        wrPtr <= wrPtr + 1'b1;
        ovflPending <= 1'b0;
      end
      // A command after the status that closed the last message opens a
      // new one; a second command before any status is RT-to-RT
      if (wordStrobe && wordKind == `BMF_KIND_CMD && (state != ST_MSG || msgDone)) begin
        // One coherent sample of all 48 bits avoids rollover tearing
        tagLatch <= timeCoh; // [R18] [R07] [R10]
        state <= ST_TAG;
        tagStep <= 2'h0;
        msgDone <= 1'b0;
      end else if (state == ST_TAG && !(ovflPending && !fifoFull)) begin
        tagStep <= tagStep + 2'h1;
        if (tagStep == 2'h2)
          state <= ST_MSG; // [R13]
      end
      if (wordStrobe && wordKind == `BMF_KIND_STAT && state == ST_MSG)
        msgDone <= 1'b1;
      if (wordStrobe && wordKind == `BMF_KIND_STAT && respRun)
        respRun <= 1'b0;
      else if (wordStrobe && wordKind != `BMF_KIND_STAT &&
               (state == ST_MSG || wordKind == `BMF_KIND_CMD))
        {respRun, respCnt} <= {1'b1, 16'h0001}; // [R02]
      else if (respRun)
        respCnt <= respCnt + 16'h0001;
      if (pushEn && pushWord[19:16] == `BMF_ID_RESP)
        respCnt <= 16'h0000;
      if (wordStrobe)
        gapCnt <= 16'h0000;
      else if (busIdle && state == ST_MSG) begin
        gapCnt <= gapCnt + 16'h0001;
        if (gapCnt >= NORESP_CYC[15:0]) begin
          state <= ST_IDLE; // [R12]
          respRun <= 1'b0;
          respCnt <= 16'h0000;
        end
      end
    end
  end
  // Bit-rate divider and frame composer
  reg [15:0] rateCnt;
  reg bitTick;
  reg [15:0] userCnt;
  reg [15:0] userHold;
  reg userPend;
  reg userSel;
  reg [8:0] wordIdx;
  reg [47:0] frameTime;
  reg [23:0] srcData;
  reg srcValid;
  reg popEn;
  wire srcReady;
  wire outValid;
  wire [23:0] outData;
  wire serReady;
  wire serWordStart;
  wire serData;
  wire [19:0] fifoHead = fifo[rdPtr[DEPTH_LOG2-1:0]];
  wire [8:0] lenSel = (frameLen < `BMF_LEN_MIN) ? `BMF_LEN_MIN :
                      (frameLen > `BMF_LEN_MAX) ? `BMF_LEN_MAX : frameLen; // [R03]
  always @* begin
    popEn = 1'b0;
    srcValid = 1'b1;
    if (wordIdx == 9'h000)
      srcData = `BMF_SYNC; // [R03]
    else if (wordIdx == 9'h001)
      srcData = {4'h0, `BMF_ID_HIGH, frameTime[47:32]}; // [R01] [R06]
    else if (wordIdx == 9'h002)
      srcData = {4'h0, `BMF_ID_LOW, frameTime[31:16]};
    else if (wordIdx == 9'h003)
      srcData = {4'h0, `BMF_ID_USEC, frameTime[15:0]};
    else if (userPend)
      srcData = {4'h0, userSel ? `BMF_ID_USER1 : `BMF_ID_USER0, userHold}; // [R17]
    else if (!fifoEmpty) begin
      srcData = {4'h0, fifoHead};
      popEn = srcReady;
    end else
      srcData = {4'h0, `BMF_ID_FILL, 16'h0000};
  end
  always @(posedge clk) begin
    if (reset) begin
      rateCnt <= 16'h0000;
      bitTick <= 1'b0;
      userCnt <= 16'h0000;
      userHold <= 16'h0000;
      userPend <= 1'b0;
      userSel <= 1'b0;
      wordIdx <= 9'h000;
      frameTime <= 48'h0;
      rdPtr <= {(DEPTH_LOG2+1){1'b0}};
      pcmData <= 1'b0;
      pcmWordStart <= 1'b0;
      pcmFrameStart <= 1'b0;
      overflowSeen <= 1'b0;
    end else begin
      bitTick <= (rateCnt == RATE_DIV - 16'd1);
      rateCnt <= (rateCnt == RATE_DIV - 16'd1) ? 16'h0000 : rateCnt + 16'h0001;
      userCnt <= (userCnt == USER_DIV - 16'd1) ? 16'h0000 : userCnt + 16'h0001;
      if (srcValid && srcReady) begin
        // Frame period is lenSel words of 24 bits at the bit rate
        wordIdx <= (wordIdx == lenSel - 9'h001) ? 9'h000 : wordIdx + 9'h001; // [R04]
        if (wordIdx == lenSel - 9'h001)
          frameTime <= timeCoh; // [R06]
        if (wordIdx > 9'h003 && userPend) begin
          userPend <= 1'b0;
          userSel <= ~userSel;
        end
      end
      // After the take, so a sample in the same cycle is not lost
      if (userCnt == USER_DIV - 16'd1) begin
        userHold <= userCoh; // [R14] [R05]
        userPend <= 1'b1;
      end
      if (popEn)
        rdPtr <= rdPtr + 1'b1; // [R11]
      pcmData <= serData;
      pcmWordStart <= serWordStart;
      pcmFrameStart <= serWordStart && (outData == `BMF_SYNC);
      if (ovflPending)
        overflowSeen <= 1'b1;
    end
  end
  bmf_skid #(.WIDTH(24)) uSkid (
    .clk(clk),
    .reset(reset),
    .inValid(srcValid),
    .inReady(srcReady),
    .inData(srcData),
    .outValid(outValid),
    .outReady(serReady),
    .outData(outData)
  );
  bmf_serializer uSer (
    .clk(clk),
    .reset(reset),
    .wordValid(outValid),
    .wordReady(serReady),
    .wordData(outData),
    .bitTick(bitTick),
    .pcmData(serData),
    .wordStart(serWordStart)
  );
endmodule // bmf_framer

`default_nettype wire

// [common/bmf_map.vh]
// Constants for the bus monitor PCM framer: word labels, sync, timing.
// Assumes an upstream decoder delivering classified 16-bit 1553 words.
// How it works
// R01 - Frame opens with high, low, microsecond time
// R02 - Response time word follows status, label 4
// R03 - Sync pattern FAF320, length 128 to 256
// R04 - Frame period equals frame bits over rate
// R05 - User word lag follows 24-bit word slots
// R06 - Frame time copies external time input
// R07 - Same message gets same tag everywhere
// R08 - Tag words latched together until all sent
// R09 - Rollover never makes tag go backwards
// R10 - Periodic message tags differ by period
// R11 - Every word kept in order, labelled right; the code drops words that arrive while the FIFO is full
// R12 - No-response message ends, resync on next
// R13 - All message kinds captured across response times
// R14 - User words sampled at configurable rate
// R15 - Structure error word labelled C or 8; a status word with an error arriving while respRun is set gets label A
// R16 - Overflow marked by extra word, label 0
// R17 - User words labelled 2 or 3
// R18 - Tag captured when command word detected
`ifndef BMF_MAP_VH
`define BMF_MAP_VH
`define BMF_ID_OVFL 4'h0
`define BMF_ID_USER0 4'h2
`define BMF_ID_USER1 4'h3
`define BMF_ID_RESP 4'h4
`define BMF_ID_USEC 4'h5
`define BMF_ID_LOW 4'h6
`define BMF_ID_HIGH 4'h7
`define BMF_ID_ERR_SEC 4'h8
`define BMF_ID_CMD 4'h9
`define BMF_ID_STAT 4'ha
`define BMF_ID_DATA 4'hb
`define BMF_ID_ERR_PRI 4'hc
`define BMF_ID_FILL 4'hf
`define BMF_SYNC 24'hfaf320
`define BMF_WORD_BITS 24
`define BMF_LEN_MIN 9'h080
`define BMF_LEN_MAX 9'h100
`define BMF_KIND_CMD 2'h0
`define BMF_KIND_STAT 2'h1
`define BMF_KIND_DATA 2'h2
`define BMF_CLK_MHZ 250
`endif

// [hdl/bmf_skid.v]
// Two-entry buffer with valid/ready on both sides.
// Assumes a single clock and synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module bmf_skid #(
  parameter WIDTH = 24
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:1];
  reg wrPtr;
  reg rdPtr;
  reg [1:0] count;
  wire doWr;
  wire doRd;
  assign inReady = (count != 2'h2);
  assign outValid = (count != 2'h0);
  assign outData = mem[rdPtr];
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;
  always @(posedge clk) begin
    if (reset) begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (doWr) begin
        mem[wrPtr] <= inData;
        wrPtr <= ~wrPtr;
      end
      if (doRd)
        rdPtr <= ~rdPtr;
      if (doWr && !doRd)
        count <= count + 2'h1;
      else if (doRd && !doWr)
        count <= count - 2'h1;
    end
  end
endmodule // bmf_skid

`default_nettype wire

// [hdl/bmf_serializer.v]
// Shifts 24-bit PCM words out MSB first at one bit per rate tick.
// Assumes bitTick is a one-cycle pulse from the framer's divider.
`timescale 1ns/10ps
`default_nettype none
module bmf_serializer (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Word input
  input wire wordValid,
  output reg wordReady,
  input wire [23:0] wordData,
  // Bit timing and output
  input wire bitTick,
  output reg pcmData,
  output reg wordStart
);
  reg [23:0] shift;
  reg [4:0] bitsLeft;
  always @(posedge clk) begin
    if (reset) begin
      shift <= 24'h000000;
      bitsLeft <= 5'h00;
      pcmData <= 1'b0;
      wordStart <= 1'b0;
      wordReady <= 1'b0;
    end else begin
      wordStart <= 1'b0;
      wordReady <= 1'b0;
      if (bitTick) begin
        if (bitsLeft == 5'h00) begin
          // An empty source still yields a 24-bit word slot (first bit zero, rest from stale wordData), so frame timing holds
          shift <= {wordData[22:0], 1'b0};
          pcmData <= wordValid ? wordData[23] : 1'b0;
          bitsLeft <= 5'd23;
          wordStart <= 1'b1;
          wordReady <= 1'b1;
        end else begin
          pcmData <= shift[23];
          shift <= {shift[22:0], 1'b0};
          bitsLeft <= bitsLeft - 5'h01;
        end
      end
    end
  end
endmodule // bmf_serializer

`default_nettype wire

// [tb/bmf_decom.sv]
// PCM decommutator model: rebuilds 24-bit words from the serial stream.
// Assumes start pulses mark a word's first bit and RATE_DIV clocks per bit.
`timescale 1ns/10ps
`default_nettype none
module bmf_decom #(
  parameter RATE_DIV = 2
) (
  // Clock and PCM stream
  input wire logic clk,
  input wire logic pcmData,
  input wire logic pcmWordStart,
  input wire logic pcmFrameStart
);
  logic [23:0] sh;
  logic [23:0] usr;
  logic [23:0] hdr [4];
  logic [23:0] msg [$];
  int nb = 0;
  int ph = 0;
  int pos = 0;
  int lastLen = 0;
  always @(posedge clk) begin
    ph = ph + 1;
    if (pcmWordStart) begin
      if (pcmFrameStart) begin
        lastLen = pos;
        pos = 0;
      end
      sh = {23'h0, pcmData};
      nb = 1;
      ph = 0;
    end else if (nb > 0 && ph == RATE_DIV) begin
      sh = {sh[22:0], pcmData};
      nb = nb + 1;
      ph = 0;
    end
    if (nb == 24) begin
      nb = 0;
      // Header, user and fill words kept off the message list
      if (pos < 4) hdr[pos] = sh;
      else if (sh[19:17] == 3'h1) usr = sh;
      else if (sh[19:16] != 4'hf) msg.push_back(sh);
      pos = pos + 1;
    end
  end
endmodule // bmf_decom
`default_nettype wire

// [tb/bmf_framer_sva.sv]
// Checker for the framer's PCM output timing and frame layout.
// Assumes it is bound to the framer; bit delays assume two clocks a bit.
`timescale 1ns/10ps
`default_nettype none
module bmf_framer_sva #(
  parameter RATE_DIV = 250
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Watched ports
  input wire logic [8:0] frameLen,
  input wire logic pcmData,
  input wire logic pcmWordStart,
  input wire logic pcmFrameStart,
  input wire logic overflowSeen
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  localparam int WP = 24 * RATE_DIV;
  int wCnt;
  int fCnt;
  logic wSeen;
  logic fSeen;
  always @(posedge clk) begin
    if (reset) begin
      wCnt <= 0;
      fCnt <= 0;
      wSeen <= 1'b0;
      fSeen <= 1'b0;
    end else begin
      wCnt <= pcmWordStart ? 0 : wCnt + 1;
      fCnt <= pcmFrameStart ? 0 : fCnt + 1;
      wSeen <= wSeen | pcmWordStart;
      fSeen <= fSeen | pcmFrameStart;
    end
  end
  sequence lab(logic [3:0] v);
    ##8 pcmData == v[3] ##2 pcmData == v[2] ##2 pcmData == v[1] ##2 pcmData == v[0];
  endsequence
  sequence syncHead;
    pcmData ##2 pcmData ##2 pcmData ##2 pcmData ##2 pcmData ##2 !pcmData ##2 pcmData;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0)
    reset |=> !pcmData && !pcmWordStart && !pcmFrameStart && !overflowSeen)
    else $error("output active after reset");
  a_frame_on_word: assert property (pcmFrameStart |-> pcmWordStart)
    else $error("frame start off word boundary");
  a_sync_head: assert property (pcmFrameStart |-> syncHead)
    else $error("sync pattern wrong");
  a_high_first: assert property (pcmFrameStart |-> ##48 lab(4'h7))
    else $error("second frame word not high time");
  a_usec_third: assert property (pcmFrameStart |-> ##144 lab(4'h5))
    else $error("fourth frame word not microsecond time");
  a_word_period: assert property (pcmWordStart && wSeen |-> wCnt == WP - 1)
    else $error("word period wrong");
  a_frame_period: assert property (pcmFrameStart && fSeen |-> fCnt == frameLen * WP - 1)
    else $error("frame period wrong");
  a_bit_hold: assert property (pcmWordStart |=> $stable(pcmData))
    else $error("bit shorter than its period");
  a_ovf_sticky: assert property (overflowSeen |=> overflowSeen)
    else $error("overflow flag dropped");
endmodule // bmf_framer_sva
bind bmf_framer bmf_framer_sva #(.RATE_DIV(RATE_DIV)) chk (.clk(clk), .reset(reset),
  .frameLen(frameLen), .pcmData(pcmData), .pcmWordStart(pcmWordStart),
  .pcmFrameStart(pcmFrameStart), .overflowSeen(overflowSeen));
`default_nettype wire

// [tb/bus_monitor_pcm_framer_tb.sv]
// Testbench for the framer: frame layout, messages, errors, user words, overflow.
// Assumes the decommutator model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module bus_monitor_pcm_framer_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wordStrobe = 1'b0;
  logic wordError = 1'b0;
  logic busIdle = 1'b1;
  logic busSecondary = 1'b0;
  int lastGap = 0;
  logic [1:0] wordKind = 2'h0;
  logic [15:0] wordValue = 16'h0;
  logic [15:0] userIn = 16'h1234;
  logic [47:0] timeIn = 48'h0a0b0c0d0e0f;
  logic pcmData, pcmWordStart, pcmFrameStart, overflowSeen;
  logic [23:0] ex [$];
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  bmf_framer #(.RATE_DIV(16'd2)) DUT (.clk(clk), .reset(reset), .frameLen(9'h080),
    .busSecondary(busSecondary), .wordStrobe(wordStrobe), .wordKind(wordKind),
    .wordValue(wordValue),
    .wordError(wordError), .busIdle(busIdle), .timeIn(timeIn), .userIn(userIn),
    .pcmData(pcmData), .pcmWordStart(pcmWordStart), .pcmFrameStart(pcmFrameStart),
    .overflowSeen(overflowSeen));
  bmf_decom #(.RATE_DIV(2)) dec (.clk(clk), .pcmData(pcmData), .pcmWordStart(pcmWordStart),
    .pcmFrameStart(pcmFrameStart));
  task report_and_stop;
    if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      failures++;
      report_and_stop;
    end
  end
  task chk(input string what, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask
  task put(input logic [1:0] k, input logic [15:0] v, input logic err, input int gap);
    @(posedge clk);
    #1;
    wordStrobe = 1'b1;
    wordKind = k;
    wordValue = v;
    wordError = err;
    busIdle = 1'b0;
    @(posedge clk);
    #1;
    wordStrobe = 1'b0;
    wordError = 1'b0;
    busIdle = 1'b1;
    repeat (gap) @(posedge clk);
    if (err) ex.push_back({busSecondary ? 8'h08 : 8'h0c, v});
    else ex.push_back({4'h0, k == 2'h0 ? 4'h9 : k == 2'h1 ? 4'ha : 4'hb, v});
    // Response time is the strobe distance in clocks: gap plus two
    if (k == 2'h1 && !err) ex.push_back({8'h04, 16'(lastGap + 2)});
    lastGap = gap;
  endtask
  task cmd(input logic [15:0] v, input int gap);
    put(2'h0, v, 1'b0, gap);
    ex.push_back({8'h07, timeIn[47:32]});
    ex.push_back({8'h06, timeIn[31:16]});
    ex.push_back({8'h05, timeIn[15:0]});
  endtask
  task verify(input int n0);
    logic [23:0] m;
    for (int t = 0; t < 20000 && dec.msg.size() < n0 + ex.size(); t++) @(posedge clk);
    foreach (ex[i]) begin
      m = dec.msg[n0 + i];
      chk("message word", ex[i], m);
    end
    ex.delete();
  endtask
  task t_frames;
    repeat (3) @(posedge pcmFrameStart);
    @(posedge clk);
    #1;
    chk("sync word", 24'hfaf320, dec.hdr[0]);
    chk("high time", {8'h07, timeIn[47:32]}, dec.hdr[1]);
    chk("low time", {8'h06, timeIn[31:16]}, dec.hdr[2]);
    chk("usec time", {8'h05, timeIn[15:0]}, dec.hdr[3]);
    chk("frame length", 24'h80, dec.lastLen[23:0]);
  endtask
  task t_msgs;
    int n0;
    n0 = dec.msg.size();
    cmd(16'h0841, 2);
    put(2'h2, 16'h0001, 1'b0, 2);
    put(2'h2, 16'h0002, 1'b0, 2);
    put(2'h1, 16'h0800, 1'b0, 1000);
    // Slow terminal answer, still inside the time-out
    cmd(16'h0c22, 2500);
    put(2'h1, 16'h0c00, 1'b0, 2);
    put(2'h2, 16'h0003, 1'b0, 1000);
    cmd(16'h1043, 2);
    put(2'h0, 16'h1c24, 1'b0, 2);
    put(2'h1, 16'h1c00, 1'b0, 2);
    put(2'h2, 16'h0004, 1'b0, 2);
    put(2'h1, 16'h1000, 1'b0, 1000);
    verify(n0);
    chk("overflow flag", 24'h0, {23'h0, overflowSeen});
  endtask
  task t_errs;
    int n0;
    n0 = dec.msg.size();
    cmd(16'h0841, 2);
    // No status follows: the next command waits out the time-out
    put(2'h2, 16'h0005, 1'b1, 4000);
    #1;
    busSecondary = 1'b1;
    cmd(16'h0c22, 2);
    put(2'h2, 16'h0007, 1'b1, 4000);
    #1;
    busSecondary = 1'b0;
    cmd(16'h0841, 2);
    put(2'h2, 16'h0006, 1'b0, 2);
    put(2'h1, 16'h0800, 1'b0, 1000);
    verify(n0);
  endtask
  task t_user;
    @(posedge clk);
    #1;
    userIn = 16'hbeef;
    repeat (2) @(posedge pcmFrameStart);
    @(posedge clk);
    #1;
    chk("user word", 24'h02beef, {dec.usr[23:17], 1'b0, dec.usr[15:0]});
  endtask
  task t_ovf;
    logic hit;
    hit = 1'b0;
    cmd(16'h0841, 2);
    repeat (100) put(2'h2, 16'h00aa, 1'b0, 2);
    ex.delete();
    chk("overflow flag", 24'h1, {23'h0, overflowSeen});
    repeat (2) @(posedge pcmFrameStart);
    foreach (dec.msg[i]) hit |= dec.msg[i][19:16] === 4'h0;
    chk("overflow word", 24'h1, {23'h0, hit});
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1;
    reset = 1'b0;
    repeat (3) @(posedge clk);
    t_frames;
    t_msgs;
    t_errs;
    t_user;
    t_ovf;
    report_and_stop;
  end
endmodule // bus_monitor_pcm_framer_tb
`default_nettype wire
